// file: common/debug_engine_defines.vh
`ifndef DEBUG_ENGINE_DEFINES_VH
`define DEBUG_ENGINE_DEFINES_VH
// Command bytes
`define CMD_RD_STATUS 8'h02
`define CMD_WR_CTRL 8'h04
`define CMD_RD_CTRL 8'h05
`define CMD_WR_PMEM 8'h0A
`define CMD_RD_PMEM 8'h0B
`define CMD_WR_DMEM 8'h0C
`define CMD_RD_DMEM 8'h0D
`define CMD_RD_CRC 8'h0E
`define CMD_STEP 8'h10
`define CMD_STUFF 8'h11
`define CMD_EXEC 8'h12
// Control register fields
`define CTL_HALT 7
`define CTL_BRK_EN 6
`define CTL_ACK_EN 5
`define CTL_SPIN 4
`define CTL_RST 0
// Fixed answers and CRC
`define FILL_BYTE 8'hFF
`define FILL_WORD 16'hFFFF
`define ACK_BYTE 8'hFF
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF
`define ARG_BYTES 3'h4
`define FULL_COUNT 17'h1_0000
`endif

// file: verilog/debug_command_engine.v
// What this block does
// R1: Program memory write data is dropped if flash locked, halt off or protected.
// R2: Memory commands take address then count, high bytes first; zero count means 65536.
// R3: Program memory read returns FFH per byte when halt off or protected.
// R4: Data memory write stores only with halt on and no protection.
// R5: Data memory read returns FFH only when halt off; protection ignored.
// R6: CRC command returns CCITT CRC of program memory, high byte first.
// R7: With halt off the CRC command returns FFFFH.
// R8: CRC answer comes after about one clock per program memory byte.
// R9: Step runs one instruction; ignored when halt off or protected.
// R10: Stuff takes one opcode byte; CPU fetches the rest from memory.
// R11: Execute takes a full 1-5 byte instruction; ignored when halt off or protected.
// R12: Host writes 81H, 41H or 40H to reset-halt, reset-run or resume.
// R13: Control bit 7 halts instruction fetch; clearing resumes; resets to zero.
// R14: A breakpoint with breakpoints enabled and spin off sets the halt bit.
// R15: While protected, writing zero to the halt bit has no effect.
// R16: Control bit 6 enables breakpoints; when zero opcode 00H is a no-op.
// R17: With control bit 5 set, FFH is sent to host on each breakpoint.
// R18: Control bit 4 picks halting or spinning on a breakpoint.
// R19: Control bit 0 resets the system but not this unit; clears when done.
// R20: Control bits 3 to 1 read zero and are written as zero.
// R21: Status bit 7 reads one when halted or breakpoint seen since control write.
// R22: Status bit 6 is CPU halt, bit 5 read protection, bits 4-0 zero.
// R23: Each command opens with one command byte; arguments then answers follow.
// R24: Answers start only after all request bytes are received.
// R25: Memory transfers step the address by one per byte.
`include "debug_engine_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module debug_command_engine #(
  parameter PM_BYTES = 17'h1_0000
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Host byte stream in
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  output wire rx_ready_o,
  // Host byte stream out
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  input wire tx_ready_i,
  // Memory port
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg pm_rd_o,
  output reg pm_wr_o,
  output reg dm_rd_o,
  output reg dm_wr_o,
  input wire [7:0] pm_rdata_i,
  input wire [7:0] dm_rdata_i,
  // CPU side
  output reg step_o,
  output reg stuff_o,
  output reg exec_byte_o,
  output reg [7:0] insn_byte_o,
  input wire [2:0] op_len_i,
  input wire brk_hit_i,
  input wire cpu_halt_i,
  output wire halt_fetch_o,
  output wire brk_enable_o,
  output wire brk_spin_o,
  // System
  input wire read_protect_i,
  input wire flash_unlocked_i,
  output wire sys_reset_o,
  input wire sys_reset_done_i
);
  localparam S_IDLE = 4'h0;
  localparam S_ARGS = 4'h1;
  localparam S_WDATA = 4'h2;
  localparam S_RREQ = 4'h3;
  localparam S_RWAIT = 4'h4;
  localparam S_RCAP = 4'h5;
  localparam S_RSEND = 4'h6;
  localparam S_CRC = 4'h7;
  localparam S_TX2 = 4'h8;
  localparam S_TX1 = 4'h9;
  localparam S_OPC = 4'hA;
  localparam S_ELEN = 4'hB;
  localparam S_EXEC = 4'hC;

  reg [3:0] state;
  reg [7:0] cmd;
  reg [15:0] addr;
  reg [16:0] left;
  reg [2:0] argn;
  reg [15:0] crc;
  reg [7:0] lo_byte;
  reg rd_d;
  reg dbg;
  reg brk_en;
  reg ack_en;
  reg spin;
  reg rst_bit;
  reg brk_seen;
  reg ack_pend;

  // One CRC-CCITT step over a byte
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c ^ {d, 8'h00};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[15] ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
      end
      crc_byte = r;
    end
  endfunction

  wire [15:0] fill_word = `FILL_WORD; // Fixed CRC answer, split into bytes below
  wire gate = ~dbg | read_protect_i;
  wire rx_take = rx_valid_i & rx_ready_o;
  wire tx_done = tx_valid_o & tx_ready_i;
  wire is_pm = (cmd == `CMD_WR_PMEM) | (cmd == `CMD_RD_PMEM);
  wire is_wr = (cmd == `CMD_WR_PMEM) | (cmd == `CMD_WR_DMEM);
  wire ctl_wr = (state == S_ARGS) & (cmd == `CMD_WR_CTRL) & rx_take;
  wire brk_act = brk_hit_i & brk_en;
  wire [7:0] ctrl_val = {dbg, brk_en, ack_en, spin, 3'h0, rst_bit}; // R20
  wire [7:0] stat_val = {dbg | brk_seen, cpu_halt_i, read_protect_i, 5'h00}; // R21 R22

  assign rx_ready_o = ((state == S_IDLE) & ~ack_pend) | (state == S_ARGS) |
                      (state == S_WDATA) | (state == S_OPC) | (state == S_EXEC);
  assign halt_fetch_o = dbg; // R13
  assign brk_enable_o = brk_en; // R16
  assign brk_spin_o = brk_en & spin; // R18
  assign sys_reset_o = rst_bit; // R19

  ////////////////////////////////////////////////////////////////////////////
  // Control register and breakpoint events
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dbg <= 1'b0; // R13
      brk_en <= 1'b0;
      ack_en <= 1'b0;
      spin <= 1'b0;
      rst_bit <= 1'b0;
      brk_seen <= 1'b0;
    end else begin
      if (ctl_wr) begin
        brk_en <= rx_data_i[`CTL_BRK_EN];
        ack_en <= rx_data_i[`CTL_ACK_EN];
        spin <= rx_data_i[`CTL_SPIN];
      end
      // Breakpoint halts unless spinning; protection blocks clearing
      if (brk_act & ~spin) begin
        dbg <= 1'b1; // R14 R18
      end else if (ctl_wr) begin
        dbg <= rx_data_i[`CTL_HALT] | (dbg & read_protect_i); // R13 R15
      end
      // Seen flag: breakpoint wins over the clear by a control write
      if (brk_act) begin
        brk_seen <= 1'b1; // R21
      end else if (ctl_wr) begin
        brk_seen <= 1'b0;
      end
      // System reset request, held until reset completes
      if (ctl_wr & rx_data_i[`CTL_RST]) begin
        rst_bit <= 1'b1; // R19
      end else if (sys_reset_done_i) begin
        rst_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      addr <= 16'h0000;
      left <= 17'h0_0000;
      argn <= 3'h0;
      crc <= `CRC_INIT;
      lo_byte <= 8'h00;
      rd_d <= 1'b0;
      ack_pend <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      pm_rd_o <= 1'b0;
      pm_wr_o <= 1'b0;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      step_o <= 1'b0;
      stuff_o <= 1'b0;
      exec_byte_o <= 1'b0;
      insn_byte_o <= 8'h00;
    end else begin
      pm_rd_o <= 1'b0;
      pm_wr_o <= 1'b0;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      step_o <= 1'b0;
      stuff_o <= 1'b0;
      exec_byte_o <= 1'b0;
      rd_d <= pm_rd_o | dm_rd_o;
      if (tx_done) begin
        tx_valid_o <= 1'b0;
      end
      // Acknowledge byte pending; new breakpoint wins over the clear
      if (brk_act & ack_en) begin
        ack_pend <= 1'b1; // R17
      end else if (state == S_IDLE & ack_pend & ~tx_valid_o) begin
        ack_pend <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (ack_pend) begin
            if (~tx_valid_o) begin
              tx_data_o <= `ACK_BYTE; // R17
              tx_valid_o <= 1'b1;
              state <= S_TX1;
            end
          end else if (rx_take) begin
            cmd <= rx_data_i; // R23
            argn <= 3'h0;
            case (rx_data_i)
              `CMD_RD_STATUS: begin
                tx_data_o <= stat_val; // R22
                tx_valid_o <= 1'b1;
                state <= S_TX1;
              end
              `CMD_RD_CTRL: begin
                tx_data_o <= ctrl_val;
                tx_valid_o <= 1'b1;
                state <= S_TX1;
              end
              `CMD_WR_CTRL, `CMD_WR_PMEM, `CMD_RD_PMEM, `CMD_WR_DMEM, `CMD_RD_DMEM: begin
                state <= S_ARGS;
              end
              `CMD_RD_CRC: begin
                crc <= `CRC_INIT;
                addr <= 16'h0000;
                left <= PM_BYTES;
                state <= S_CRC;
              end
              `CMD_STEP: begin
                step_o <= ~gate; // R9
              end
              `CMD_STUFF, `CMD_EXEC: begin
                state <= S_OPC;
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_ARGS: begin
          if (rx_take) begin
            argn <= argn + 3'h1;
            if (cmd == `CMD_WR_CTRL) begin
              state <= S_IDLE;
            end else begin
              // Address then count, high bytes first
              case (argn)
                3'h0: addr[15:8] <= rx_data_i; // R2
                3'h1: addr[7:0] <= rx_data_i;
                3'h2: left[15:8] <= rx_data_i;
                default: left[7:0] <= rx_data_i;
              endcase
              if (argn == `ARG_BYTES - 3'h1) begin
                if ({left[15:8], rx_data_i} == 16'h0000) begin
                  left <= `FULL_COUNT; // R2
                end else begin
                  left <= {1'b0, left[15:8], rx_data_i};
                end
                state <= is_wr ? S_WDATA : S_RREQ; // R24
              end
            end
          end
        end
        S_WDATA: begin
          if (rx_take) begin
            mem_addr_o <= addr;
            mem_wdata_o <= rx_data_i;
            pm_wr_o <= is_pm & flash_unlocked_i & ~gate; // R1
            dm_wr_o <= ~is_pm & ~gate; // R4
            addr <= addr + 16'h0001; // R25
            left <= left - 17'h0_0001;
            if (left == 17'h0_0001) begin
              state <= S_IDLE;
            end
          end
        end
        S_RREQ: begin
          if (~tx_valid_o) begin
            mem_addr_o <= addr;
            pm_rd_o <= is_pm & ~gate;
            dm_rd_o <= ~is_pm & dbg;
            state <= S_RWAIT;
          end
        end
        S_RWAIT: begin
          state <= S_RCAP;
        end
        S_RCAP: begin
          if (is_pm) begin
            tx_data_o <= gate ? `FILL_BYTE : pm_rdata_i; // R3
          end else begin
            tx_data_o <= dbg ? dm_rdata_i : `FILL_BYTE; // R5
          end
          tx_valid_o <= 1'b1;
          state <= S_RSEND;
        end
        S_RSEND: begin
          if (tx_done) begin
            addr <= addr + 16'h0001; // R25
            left <= left - 17'h0_0001;
            state <= (left == 17'h0_0001) ? S_IDLE : S_RREQ;
          end
        end
        S_CRC: begin
          // With halt on, one byte per clock, answered once memory is walked
          if (~dbg) begin
            tx_data_o <= fill_word[15:8]; // R7
            lo_byte <= fill_word[7:0];
            tx_valid_o <= 1'b1;
            state <= S_TX2;
          end else if (left != 17'h0_0000) begin
            mem_addr_o <= addr;
            pm_rd_o <= 1'b1; // R8
            addr <= addr + 16'h0001;
            left <= left - 17'h0_0001;
          end else if (~pm_rd_o & ~rd_d) begin
            tx_data_o <= crc[15:8]; // R6
            lo_byte <= crc[7:0];
            tx_valid_o <= 1'b1;
            state <= S_TX2;
          end
          if (rd_d) begin
            crc <= crc_byte(crc, pm_rdata_i); // R6
          end
        end
        S_TX2: begin
          if (tx_done) begin
            tx_data_o <= lo_byte;
            tx_valid_o <= 1'b1;
            state <= S_TX1;
          end
        end
        S_TX1: begin
          if (tx_done) begin
            state <= S_IDLE;
          end
        end
        S_OPC: begin
          if (rx_take) begin
            insn_byte_o <= rx_data_i;
            if (cmd == `CMD_STUFF) begin
              stuff_o <= ~gate; // R10
              state <= S_IDLE;
            end else begin
              exec_byte_o <= ~gate; // R11
              state <= S_ELEN;
            end
          end
        end
        S_ELEN: begin
          // CPU decodes the length of the first byte
          left <= {14'h0000, op_len_i} - 17'h0_0001; // R11
          state <= (op_len_i > 3'h1) ? S_EXEC : S_IDLE;
        end
        S_EXEC: begin
          if (rx_take) begin
            insn_byte_o <= rx_data_i;
            exec_byte_o <= ~gate; // R11
            left <= left - 17'h0_0001;
            if (left == 17'h0_0001) begin
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // debug_command_engine
`default_nettype wire

// file: verification/debug_engine_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks for the debug command engine
module debug_engine_asserts #(
  parameter PM_BYTES = 17'h1_0000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host stream
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // Strobes and control
  input wire logic pm_wr_o,
  input wire logic dm_wr_o,
  input wire logic step_o,
  input wire logic exec_byte_o,
  input wire logic brk_hit_i,
  input wire logic halt_fetch_o,
  input wire logic brk_enable_o,
  input wire logic brk_spin_o,
  input wire logic read_protect_i,
  input wire logic flash_unlocked_i,
  input wire logic sys_reset_o,
  input wire logic sys_reset_done_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Strobes only pass open gates
  pm_gate_a: assert property (pm_wr_o |-> halt_fetch_o && flash_unlocked_i && !read_protect_i)
    else $error("program write while gated");
  dm_gate_a: assert property (dm_wr_o |-> halt_fetch_o && !read_protect_i)
    else $error("data write while gated");
  step_gate_a: assert property (step_o |-> halt_fetch_o && !read_protect_i)
    else $error("step while gated");
  exec_gate_a: assert property (exec_byte_o |-> halt_fetch_o && !read_protect_i)
    else $error("execute while gated");
  // Breakpoint and halt bit behaviour
  brk_halt_a: assert property (brk_hit_i && brk_enable_o && !brk_spin_o |=> halt_fetch_o)
    else $error("breakpoint did not halt");
  spin_keep_a: assert property (brk_hit_i && brk_spin_o && !halt_fetch_o |=> !halt_fetch_o)
    else $error("spinning breakpoint halted");
  protect_hold_a: assert property (read_protect_i && halt_fetch_o |=> halt_fetch_o)
    else $error("halt cleared while protected");
  // Answer stream holds and blocks requests; reset bit clears after reset done
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("answer byte dropped");
  rx_block_a: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("request taken while answering");
  rst_clear_a: assert property (sys_reset_done_i |=> !sys_reset_o)
    else $error("reset bit stuck");
endmodule // debug_engine_asserts
bind debug_command_engine debug_engine_asserts #(.PM_BYTES(PM_BYTES)) debug_engine_asserts_i (
  .core_clk_i, .rst_n_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .pm_wr_o,
  .dm_wr_o, .step_o, .exec_byte_o, .brk_hit_i, .halt_fetch_o, .brk_enable_o, .brk_spin_o,
  .read_protect_i, .flash_unlocked_i, .sys_reset_o, .sys_reset_done_i);
`default_nettype wire

// file: verification/debug_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Program and data memory behind the engine's memory port
module debug_mem_model (
  // Clock
  input wire logic core_clk_i,
  // Memory port
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic pm_rd_i,
  input wire logic pm_wr_i,
  input wire logic dm_rd_i,
  input wire logic dm_wr_i,
  output var logic [7:0] pm_rdata_o = 8'h00,
  output var logic [7:0] dm_rdata_o = 8'h00
);
  logic [7:0] pm [0:255];
  logic [7:0] dm [0:255];
  // Known fill: program cell i holds i
  initial begin
    for (int i = 0; i < 256; i++) begin
      pm[i] = i[7:0];
      dm[i] = ~i[7:0];
    end
  end
  // Data valid the cycle after a strobe, toggling otherwise so stale data never matches
  always @(posedge core_clk_i) begin
    pm_rdata_o <= pm_rd_i ? pm[mem_addr_i[7:0]] : ~pm_rdata_o;
    dm_rdata_o <= dm_rd_i ? dm[mem_addr_i[7:0]] : ~dm_rdata_o;
    if (pm_wr_i) pm[mem_addr_i[7:0]] <= mem_wdata_i;
    if (dm_wr_i) dm[mem_addr_i[7:0]] <= mem_wdata_i;
  end
endmodule // debug_mem_model
`default_nettype wire

// file: verification/onchip_debug_command_engine_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_engine_defines.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module onchip_debug_command_engine_test;
  localparam int PMB = 16;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, rx_valid_i = 1'b0, tx_ready_i = 1'b0;
  logic brk_hit_i = 1'b0, cpu_halt_i = 1'b0, read_protect_i = 1'b0, flash_unlocked_i = 1'b1;
  logic sys_reset_done_i = 1'b0, rx_ready_o, tx_valid_o, pm_rd_o, pm_wr_o, dm_rd_o, dm_wr_o;
  logic step_o, stuff_o, exec_byte_o, halt_fetch_o, brk_enable_o, brk_spin_o, sys_reset_o;
  logic [7:0] rx_data_i = 8'h00, tx_data_o, insn_byte_o, pm_rdata_i, dm_rdata_i, mem_wdata_o;
  logic [2:0] op_len_i = 3'h2;
  logic [15:0] mem_addr_o;
  logic [15:0] crc;
  int mismatches = 0, num_checks = 0, cycles = 0, waited = 0, pulses = 0;
  debug_command_engine #(.PM_BYTES(17'h0_0010)) debug_command_engine_i (.core_clk_i, .rst_n_i,
    .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .mem_addr_o,
    .mem_wdata_o, .pm_rd_o, .pm_wr_o, .dm_rd_o, .dm_wr_o, .pm_rdata_i, .dm_rdata_i, .step_o,
    .stuff_o, .exec_byte_o, .insn_byte_o, .op_len_i, .brk_hit_i, .cpu_halt_i, .halt_fetch_o,
    .brk_enable_o, .brk_spin_o, .read_protect_i, .flash_unlocked_i, .sys_reset_o,
    .sys_reset_done_i);
  debug_mem_model debug_mem_model_i (.core_clk_i, .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .pm_rd_i(pm_rd_o), .pm_wr_i(pm_wr_o), .dm_rd_i(dm_rd_o),
    .dm_wr_i(dm_wr_o), .pm_rdata_o(pm_rdata_i), .dm_rdata_o(dm_rdata_i));
  // Clock, CPU pulse count and hang guard
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (step_o | stuff_o | exec_byte_o) pulses++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Offer one byte, held until taken
  task automatic send(input logic [7:0] b);
    @(negedge core_clk_i);
    rx_valid_i = 1'b1;
    rx_data_i = b;
    while (rx_ready_o !== 1'b1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    rx_valid_i = 1'b0;
  endtask
  // Wait for an answer byte, compare, accept
  task automatic recv(input logic [7:0] e);
    waited = 0;
    while (tx_valid_o !== 1'b1 && waited < 500) begin
      @(negedge core_clk_i);
      waited++;
    end
    `CHK(tx_data_o, e)
    tx_ready_i = 1'b1;
    @(negedge core_clk_i);
    tx_ready_i = 1'b0;
  endtask
  // Callers keep control bits 3 to 1 at zero
  task automatic wr_ctl(input logic [7:0] v);
    send(`CMD_WR_CTRL);
    send(v);
  endtask
  task automatic mem(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
    send(c);
    send(a[15:8]);
    send(a[7:0]);
    send(n[15:8]);
    send(n[7:0]);
  endtask
  task automatic brk_pulse;
    @(negedge core_clk_i);
    brk_hit_i = 1'b1;
    @(negedge core_clk_i);
    brk_hit_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    send(`CMD_RD_CTRL); recv(8'h00);
    wr_ctl(8'hE0); send(`CMD_RD_CTRL); recv(8'hE0);
    `CHK(halt_fetch_o, 1'b1)
    `CHK(brk_enable_o, 1'b1)
    cpu_halt_i = 1'b1; read_protect_i = 1'b1;
    send(`CMD_RD_STATUS); recv(8'hE0);
    wr_ctl(8'h00); send(`CMD_RD_CTRL); recv(8'h80);
    cpu_halt_i = 1'b0; read_protect_i = 1'b0;
    wr_ctl(8'h00); send(`CMD_RD_STATUS); recv(8'h00);
  endtask
  task automatic t_mem;
    wr_ctl(8'h80);
    mem(`CMD_WR_PMEM, 16'h0005, 16'h0002); send(8'hA5); send(8'h5A);
    mem(`CMD_RD_PMEM, 16'h0005, 16'h0002); recv(8'hA5); recv(8'h5A);
    mem(`CMD_WR_DMEM, 16'h0010, 16'h0001); send(8'h3C);
    mem(`CMD_RD_DMEM, 16'h0010, 16'h0001); recv(8'h3C);
    flash_unlocked_i = 1'b0;
    mem(`CMD_WR_PMEM, 16'h0007, 16'h0001); send(8'h11);
    flash_unlocked_i = 1'b1;
    mem(`CMD_RD_PMEM, 16'h0007, 16'h0001); recv(8'h07);
    read_protect_i = 1'b1;
    mem(`CMD_RD_PMEM, 16'h0005, 16'h0001); recv(`FILL_BYTE);
    mem(`CMD_RD_DMEM, 16'h0010, 16'h0001); recv(8'h3C);
    read_protect_i = 1'b0; wr_ctl(8'h00);
    mem(`CMD_RD_DMEM, 16'h0010, 16'h0001); recv(`FILL_BYTE);
    mem(`CMD_RD_PMEM, 16'h0005, 16'h0001); recv(`FILL_BYTE);
  endtask
  task automatic t_crc;
    logic [7:0] b;
    send(`CMD_RD_CRC); recv(8'hFF); recv(8'hFF);
    crc = `CRC_INIT;
    for (int i = 0; i < PMB; i++) begin
      b = (i == 5) ? 8'hA5 : (i == 6) ? 8'h5A : i[7:0];
      for (int k = 7; k >= 0; k--) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[k]) ? `CRC_POLY : 0);
    end
    wr_ctl(8'h80); send(`CMD_RD_CRC); recv(crc[15:8]);
    `CHK(waited >= PMB, 1'b1)
    recv(crc[7:0]);
  endtask
  task automatic t_cpu;
    pulses = 0;
    send(`CMD_STEP); repeat (3) @(negedge core_clk_i); `CHK(pulses, 1)
    send(`CMD_STUFF); send(8'h3C); repeat (3) @(negedge core_clk_i); `CHK(pulses, 2)
    `CHK(insn_byte_o, 8'h3C)
    send(`CMD_EXEC); send(8'h21); send(8'h05); repeat (3) @(negedge core_clk_i);
    `CHK(pulses, 4)
    `CHK(insn_byte_o, 8'h05)
    wr_ctl(8'h00); send(`CMD_STEP); repeat (3) @(negedge core_clk_i); `CHK(pulses, 4)
  endtask
  task automatic t_brk;
    wr_ctl(8'h60); brk_pulse(); recv(`ACK_BYTE);
    send(`CMD_RD_CTRL); recv(8'hE0);
    wr_ctl(8'h70); brk_pulse(); recv(`ACK_BYTE);
    `CHK(brk_spin_o, 1'b1)
    send(`CMD_RD_STATUS); recv(8'h80);
    send(`CMD_RD_CTRL); recv(8'h70);
  endtask
  task automatic t_rst;
    wr_ctl(8'h81); @(negedge core_clk_i); `CHK(sys_reset_o, 1'b1)
    sys_reset_done_i = 1'b1; @(negedge core_clk_i); sys_reset_done_i = 1'b0;
    @(negedge core_clk_i); `CHK(sys_reset_o, 1'b0)
    send(`CMD_RD_CTRL); recv(8'h80);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_regs(); t_mem(); t_crc(); t_cpu(); t_brk(); t_rst();
    give_verdict();
  end
endmodule // onchip_debug_command_engine_test
`default_nettype wire
